// *** design/file_alu_exec.v ***
// decode and execution of the logical, arithmetic, step, rotate, swap and
// clear instructions on a 32-byte file and an accumulator.
// assumes a same-clock sequencer that offers one opcode per cycle and
// honours the skip indication; registers are reached over axi4-lite.
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "file_alu_regs.vh"

// Operation
// - plain operations retire in one cycle
// - skip taken costs one extra discarded cycle
// - runs only when config bit 11 is 0
// - three and forms, zero flag only
// - three or forms, zero flag only
// - three xor forms, zero flag only
// - complement file operand, update zero flag
// - add with optional carry in, three flags
// - subtract with optional inverted carry, three flags
// - clear watchdog: pulse, prescaler, set flags
// - decrement file operand, update zero flag
// - decrement, skip on zero, no flags
// - increment file operand, update zero flag
// - increment, skip on zero, no flags
// - rotate through carry, carry flag only
// - swap nibbles in place, no flags
// - carry, digit, zero at status bits 0-2
// - power-down bit 3, timeout bit 4
module file_alu_exec (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address and data
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    // axi4-lite write response
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    // axi4-lite read
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    // sequencer
    input wire instr_valid,
    input wire [11:0] instr_word,
    output wire instr_ready,
    output wire skip_next,
    // watchdog
    output wire watchdog_clear,
    output wire prescaler_clear,
    // state view
    output wire [7:0] accum,
    output wire [4:0] status_flags
);

    // software state
    reg [1:0] ctrl_r;
    reg [11:0] primary_config_word_r;
    reg [4:0] file_ptr_r;
    // execution state
    reg [7:0] accum_r;
    reg [4:0] status_r;
    reg skip_pend_r;
    reg skip_next_r;
    reg watch_clr_r;
    reg pre_clr_r;
    reg [31:0] retired_r;
    reg [31:0] skipped_r;
    reg [7:0] file_mem [0:31];

    // decode outputs
    reg [3:0] alu_op;
    reg dst_w;
    reg use_lit;
    reg upd_z;
    reg upd_c;
    reg upd_digit;
    reg skip_op;
    reg watch_op;

    // register bus side
    wire reg_wr;
    wire [7:0] reg_waddr;
    wire [31:0] reg_wdata;
    wire [3:0] reg_wstrb;
    reg [31:0] reg_rdata;

    // alu side
    wire [4:0] file_addr;
    wire [7:0] literal;
    wire [7:0] file_operand;
    wire [7:0] alu_res;
    wire alu_carry;
    wire alu_digit;
    wire take;
    wire exec;

    function reg_hit;
        input [7:0] a;
        begin
            reg_hit = (a == `OFS_CTRL) || (a == `OFS_CONFIG) ||
                (a == `OFS_ACCUM) || (a == `OFS_STATUS) ||
                (a == `OFS_FILE_PTR) || (a == `OFS_FILE_DATA) ||
                (a == `OFS_RETIRED) || (a == `OFS_SKIPPED);
        end
    endfunction

    function is_zero;
        input [7:0] v;
        begin
            is_zero = (v == 8'h00);
        end
    endfunction

    assign file_addr = instr_word[4:0];
    assign literal = instr_word[7:0];
    assign file_operand = file_mem[file_addr];

    // a set fuse bit selects a divider this block lacks, so it holds off
    assign instr_ready = !primary_config_word_r[`CFG_DIV_SEL];
    // one opcode taken per edge, no wait states
    assign take = instr_valid && instr_ready;
    // the opcode after a taken skip is accepted and dropped
    assign exec = take && !skip_pend_r;

    assign skip_next = skip_next_r;
    assign watchdog_clear = watch_clr_r;
    assign prescaler_clear = pre_clr_r;
    assign accum = accum_r;
    assign status_flags = status_r;

    // decode
    always @* begin
        alu_op = `OP_NONE;
        dst_w = 1'b0;
        use_lit = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_digit = 1'b0;
        skip_op = 1'b0;
        watch_op = 1'b0;
        if (instr_word == `INS_CLR_W) begin
            alu_op = `OP_CLR;
            dst_w = 1'b1;
            upd_z = 1'b1;
        end else if (instr_word == `INS_CLR_WATCH) begin
            watch_op = 1'b1;
        end else begin
            case (instr_word[11:8])
                `LIT_AND: begin
                    alu_op = `OP_AND;
                    use_lit = 1'b1;
                    dst_w = 1'b1;
                    upd_z = 1'b1;
                end
                `LIT_OR: begin
                    alu_op = `OP_OR;
                    use_lit = 1'b1;
                    dst_w = 1'b1;
                    upd_z = 1'b1;
                end
                `LIT_XOR: begin
                    alu_op = `OP_XOR;
                    use_lit = 1'b1;
                    dst_w = 1'b1;
                    upd_z = 1'b1;
                end
                default: begin
                    case (instr_word[11:5])
                        `F_AND_F, `F_AND_W: begin
                            alu_op = `OP_AND;
                            upd_z = 1'b1;
                        end
                        `F_OR_F, `F_OR_W: begin
                            alu_op = `OP_OR;
                            upd_z = 1'b1;
                        end
                        `F_XOR_F, `F_XOR_W: begin
                            alu_op = `OP_XOR;
                            upd_z = 1'b1;
                        end
                        `F_NOT: begin
                            alu_op = `OP_NOT;
                            upd_z = 1'b1;
                        end
                        `F_ADD_F, `F_ADD_W: begin
                            alu_op = `OP_ADD;
                            upd_z = 1'b1;
                            upd_c = 1'b1;
                            upd_digit = 1'b1;
                        end
                        `F_SUB: begin
                            alu_op = `OP_SUB;
                            upd_z = 1'b1;
                            upd_c = 1'b1;
                            upd_digit = 1'b1;
                        end
                        `F_CLR: begin
                            alu_op = `OP_CLR;
                            upd_z = 1'b1;
                        end
                        `F_DEC: begin
                            alu_op = `OP_DEC;
                            upd_z = 1'b1;
                        end
                        `F_INC: begin
                            alu_op = `OP_INC;
                            upd_z = 1'b1;
                        end
                        `F_DEC_SKIP: begin
                            alu_op = `OP_DEC;
                            skip_op = 1'b1;
                        end
                        `F_INC_SKIP: begin
                            alu_op = `OP_INC;
                            skip_op = 1'b1;
                        end
                        `F_ROTL, `F_ROTR: begin
                            alu_op = instr_word[6] ? `OP_ROTL : `OP_ROTR;
                            upd_c = 1'b1;
                        end
                        `F_SWAP: alu_op = `OP_SWAP;
                        // opcodes outside this block retire as no-ops
                        default: alu_op = `OP_NONE;
                    endcase
                    // even low bit of these forms targets the accumulator
                    dst_w = (instr_word[11:5] == `F_AND_W) ||
                        (instr_word[11:5] == `F_OR_W) ||
                        (instr_word[11:5] == `F_XOR_W) ||
                        (instr_word[11:5] == `F_ADD_W);
                end
            endcase
        end
    end

    alu8_core u_alu (
        .op(alu_op),
        .opa(use_lit ? literal : file_operand),
        .w(accum_r),
        .carry_in(status_r[`ST_CARRY]),
        .carry_in_enable_n(ctrl_r[`CTRL_CARRY_EN_N]),
        .res(alu_res),
        .carry_out(alu_carry),
        .digit_out(alu_digit)
    );

    // file array: software write first, execution wins on the same byte
    always @(posedge aclk) begin
        if (reg_wr && reg_waddr == `OFS_FILE_DATA && reg_wstrb[0]) begin
            file_mem[file_ptr_r] <= reg_wdata[7:0];
        end
        if (exec && alu_op != `OP_NONE && !dst_w) begin
            file_mem[file_addr] <= alu_res;
        end
    end

    // registers and execution
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `RST_CTRL;
            primary_config_word_r <= `RST_CONFIG;
            file_ptr_r <= 5'h00;
            accum_r <= `RST_ACCUM;
            status_r <= `RST_STATUS;
            skip_pend_r <= 1'b0;
            skip_next_r <= 1'b0;
            watch_clr_r <= 1'b0;
            pre_clr_r <= 1'b0;
            retired_r <= 32'h0000_0000;
            skipped_r <= 32'h0000_0000;
        end else begin
            skip_next_r <= 1'b0;
            watch_clr_r <= 1'b0;
            pre_clr_r <= 1'b0;
            if (reg_wr && reg_wstrb[0]) begin
                case (reg_waddr)
                    `OFS_CTRL: ctrl_r <= reg_wdata[1:0];
                    `OFS_CONFIG: primary_config_word_r[7:0] <=
                        reg_wdata[7:0];
                    `OFS_ACCUM: accum_r <= reg_wdata[7:0];
                    `OFS_STATUS: status_r <= reg_wdata[4:0];
                    `OFS_FILE_PTR: file_ptr_r <= reg_wdata[4:0];
                    default: ctrl_r <= ctrl_r;
                endcase
            end
            if (reg_wr && reg_wstrb[1] && reg_waddr == `OFS_CONFIG) begin
                primary_config_word_r[11:8] <= reg_wdata[11:8];
            end
            // execution after software so hardware flag sets win
            if (take && skip_pend_r) begin
                skip_pend_r <= 1'b0;
                skipped_r <= skipped_r + 32'h0000_0001;
            end
            if (exec) begin
                retired_r <= retired_r + 32'h0000_0001;
                if (alu_op != `OP_NONE && dst_w) begin
                    accum_r <= alu_res;
                end
                if (upd_z) begin
                    status_r[`ST_ZERO] <= is_zero(alu_res);
                end
                if (upd_c) begin
                    status_r[`ST_CARRY] <= alu_carry;
                end
                if (upd_digit) begin
                    status_r[`ST_DIGIT] <= alu_digit;
                end
                if (skip_op && is_zero(alu_res)) begin
                    skip_pend_r <= 1'b1;
                    skip_next_r <= 1'b1;
                end
                if (watch_op) begin
                    status_r[`ST_TIMEOUT] <= 1'b1;
                    status_r[`ST_POWER_DOWN] <= 1'b1;
                    watch_clr_r <= 1'b1;
                    pre_clr_r <= ctrl_r[`CTRL_PRESCALE_WATCH];
                end
            end
        end
    end

    // read mux; reserved bits read as zero
    always @* begin
        case (araddr)
            `OFS_CTRL: reg_rdata = {30'h0, ctrl_r};
            `OFS_CONFIG: reg_rdata = {20'h0, primary_config_word_r};
            `OFS_ACCUM: reg_rdata = {24'h0, accum_r};
            `OFS_STATUS: reg_rdata = {27'h0, status_r};
            `OFS_FILE_PTR: reg_rdata = {27'h0, file_ptr_r};
            `OFS_FILE_DATA: reg_rdata = {24'h0, file_mem[file_ptr_r]};
            `OFS_RETIRED: reg_rdata = retired_r;
            `OFS_SKIPPED: reg_rdata = skipped_r;
            default: reg_rdata = 32'h0000_0000;
        endcase
    end

    axil_reg_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .reg_wr(reg_wr),
        .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata),
        .reg_wstrb(reg_wstrb),
        .reg_whit(reg_hit(reg_waddr)),
        .reg_rdata(reg_rdata),
        .reg_rhit(reg_hit(araddr))
    );

endmodule

// *** design/file_alu_regs.vh ***
// constants for the file-operand alu: register map, fields, reset values,
// alu operation codes and opcode patterns.
// assumes inclusion by every design file of the block.
`ifndef FILE_ALU_REGS_VH
`define FILE_ALU_REGS_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_CONFIG 8'h04
`define OFS_ACCUM 8'h08
`define OFS_STATUS 8'h0C
`define OFS_FILE_PTR 8'h10
`define OFS_FILE_DATA 8'h14
`define OFS_RETIRED 8'h18
`define OFS_SKIPPED 8'h1C

// field positions
`define CTRL_CARRY_EN_N 0
`define CTRL_PRESCALE_WATCH 1
`define CFG_DIV_SEL 11
`define ST_CARRY 0
`define ST_DIGIT 1
`define ST_ZERO 2
`define ST_POWER_DOWN 3
`define ST_TIMEOUT 4

// reset values
`define RST_CTRL 2'h1
`define RST_CONFIG 12'h000
`define RST_ACCUM 8'h00
`define RST_STATUS 5'h18

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// alu operation codes
`define OP_NONE 4'h0
`define OP_AND 4'h1
`define OP_OR 4'h2
`define OP_XOR 4'h3
`define OP_NOT 4'h4
`define OP_ADD 4'h5
`define OP_SUB 4'h6
`define OP_INC 4'h7
`define OP_DEC 4'h8
`define OP_ROTL 4'h9
`define OP_ROTR 4'hA
`define OP_SWAP 4'hB
`define OP_CLR 4'hC

// whole-word opcodes
`define INS_CLR_W 12'h040
`define INS_CLR_WATCH 12'h004

// literal forms, instruction bits 11:8
`define LIT_OR 4'hD
`define LIT_AND 4'hE
`define LIT_XOR 4'hF

// file-operand forms, instruction bits 11:5
`define F_CLR 7'h03
`define F_SUB 7'h05
`define F_DEC 7'h07
`define F_OR_W 7'h08
`define F_OR_F 7'h09
`define F_AND_W 7'h0A
`define F_AND_F 7'h0B
`define F_XOR_W 7'h0C
`define F_XOR_F 7'h0D
`define F_ADD_W 7'h0E
`define F_ADD_F 7'h0F
`define F_NOT 7'h13
`define F_INC 7'h15
`define F_DEC_SKIP 7'h17
`define F_ROTR 7'h19
`define F_ROTL 7'h1B
`define F_SWAP 7'h1D
`define F_INC_SKIP 7'h1F

`endif

// *** design/alu8_core.v ***
// combinational 8-bit alu: logic, add/subtract, step, rotate, swap, clear.
// assumes the caller decodes the operation and owns every flag register.
`timescale 1ns/10ps
`include "file_alu_regs.vh"

module alu8_core (
    // operation and operands
    input wire [3:0] op,
    input wire [7:0] opa,
    input wire [7:0] w,
    input wire carry_in,
    input wire carry_in_enable_n,
    // results
    output reg [7:0] res,
    output reg carry_out,
    output reg digit_out
);

    reg sub;
    reg cin;
    reg [7:0] opb;
    reg [8:0] sum9;
    reg [4:0] nib;

    // subtract is opa + ~w + cin, so carry means no borrow
    always @* begin
        sub = (op == `OP_SUB);
        opb = sub ? ~w : w;
        cin = carry_in_enable_n ? sub : carry_in;
        sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
        nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        res = opa;
        carry_out = carry_in;
        digit_out = 1'b0;
        case (op)
            `OP_AND: res = opa & w;
            `OP_OR: res = opa | w;
            `OP_XOR: res = opa ^ w;
            `OP_NOT: res = opa ^ 8'hFF;
            `OP_ADD, `OP_SUB: begin
                res = sum9[7:0];
                carry_out = sum9[8];
                digit_out = nib[4];
            end
            `OP_INC: res = opa + 8'h01;
            `OP_DEC: res = opa - 8'h01;
            `OP_ROTL: begin
                res = {opa[6:0], carry_in};
                carry_out = opa[7];
            end
            `OP_ROTR: begin
                res = {carry_in, opa[7:1]};
                carry_out = opa[0];
            end
            `OP_SWAP: res = {opa[3:0], opa[7:4]};
            `OP_CLR: res = 8'h00;
            default: res = opa;
        endcase
    end

endmodule

// *** design/axil_reg_slave.v ***
// axi4-lite slave front end: takes address and data in either order,
// hands one register write and one register read at a time to the owner of the registers.
// assumes the owner decodes addresses combinationally.
`timescale 1ns/10ps
`include "file_alu_regs.vh"

module axil_reg_slave (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write address and data
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    // write response
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // read
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // register side
    output wire reg_wr,
    output reg [7:0] reg_waddr,
    output reg [31:0] reg_wdata,
    output reg [3:0] reg_wstrb,
    input wire reg_whit,
    input wire [31:0] reg_rdata,
    input wire reg_rhit
);

    reg aw_full_r;
    reg w_full_r;

    assign awready = !aw_full_r && !bvalid;
    assign wready = !w_full_r && !bvalid;
    assign reg_wr = aw_full_r && w_full_r && !bvalid;
    // one read outstanding; the owner decodes araddr directly
    assign arready = !rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            reg_waddr <= 8'h00;
            reg_wdata <= 32'h0000_0000;
            reg_wstrb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_full_r <= 1'b1;
                reg_waddr <= awaddr;
            end
            if (wvalid && wready) begin
                w_full_r <= 1'b1;
                reg_wdata <= wdata;
                reg_wstrb <= wstrb;
            end
            if (reg_wr) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= reg_whit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= reg_rdata;
                rresp <= reg_rhit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule

// *** test/file_alu_exec_monitor.sv ***
// concurrent checks on the ports of file_alu_exec, bound below.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module file_alu_exec_monitor (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus
    input wire bvalid,
    input wire bready,
    input wire rvalid,
    input wire rready,
    // sequencer and state
    input wire instr_valid,
    input wire [11:0] instr_word,
    input wire instr_ready,
    input wire skip_next,
    input wire watchdog_clear,
    input wire [7:0] accum,
    input wire [4:0] status_flags
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // an opcode taken while skip_next is up is dropped
    wire tk = instr_valid && instr_ready && !skip_next;
    wire [3:0] hi = instr_word[11:8];
    wire [7:0] k = instr_word[7:0];
    lit_and_a: assert property (
        tk && hi == 4'hE |=> accum == ($past(accum) & $past(k)))
        else $error("and literal result");
    lit_or_a: assert property (
        tk && hi == 4'hD |=> accum == ($past(accum) | $past(k)))
        else $error("or literal result");
    lit_xor_a: assert property (
        tk && hi == 4'hF |=> accum == ($past(accum) ^ $past(k)))
        else $error("xor literal result");
    zero_flag_a: assert property (
        tk && hi >= 4'hD |=> status_flags[2] == (accum == 8'h00))
        else $error("zero flag");
    clr_accum_a: assert property (
        tk && instr_word == 12'h040 |=> accum == 8'h00 && status_flags[2])
        else $error("clear accumulator");
    wdog_pulse_a: assert property (
        tk && instr_word == 12'h004 |=>
        watchdog_clear && status_flags[4:3] == 2'h3)
        else $error("watchdog clear");
    wdog_cause_a: assert property (
        watchdog_clear |-> $past(instr_word) == 12'h004)
        else $error("spurious watchdog clear");
    skip_flags_a: assert property (
        tk && (instr_word[11:5] == 7'h17 || instr_word[11:5] == 7'h1F)
        |=> $stable(status_flags)) else $error("skip op changed flags");
    skip_once_a: assert property (
        skip_next |=> !skip_next) else $error("skip twice");
    lit_noskip_a: assert property (
        tk && hi >= 4'hD |=> !skip_next) else $error("literal skipped");
    resp_hold_a: assert property (
        bvalid && !bready |=> bvalid) else $error("bvalid dropped");
    read_hold_a: assert property (
        rvalid && !rready |=> rvalid) else $error("rvalid dropped");
    cover property (skip_next);
    cover property (watchdog_clear);
    cover property (tk && hi == 4'hE);
endmodule
bind file_alu_exec file_alu_exec_monitor i_mon (.aclk(aclk),
    .aresetn(aresetn), .bvalid(bvalid), .bready(bready), .rvalid(rvalid),
    .rready(rready), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .skip_next(skip_next),
    .watchdog_clear(watchdog_clear), .accum(accum),
    .status_flags(status_flags));

// *** test/seq_model.sv ***
// opcode source standing in for the fetch and sequencer logic.
// assumes the bench calls issue back to back, then idle.
`timescale 1ns/10ps
module seq_model (
    // clock
    input wire aclk,
    // opcode stream
    input wire instr_ready,
    output logic instr_valid,
    output logic [11:0] instr_word
);
    initial begin
        instr_valid = 1'b0;
        instr_word = 12'h000;
    end
    task issue(input [11:0] w);
        instr_valid <= 1'b1;
        instr_word <= w;
        do @(posedge aclk); while (!instr_ready);
    endtask
    // released word is scrambled so stale opcodes never look valid
    task idle();
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
        @(posedge aclk);
    endtask
endmodule

// *** test/tb.sv ***
// self-checking bench for file_alu_exec over axi4-lite and opcodes.
// assumes seq_model and the bound monitor are compiled before it.
`timescale 1ns/10ps
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rd_v;
    logic [3:0] wstrb;
    logic [1:0] rs, bs;
    wire awready, wready, bvalid, arready, rvalid, instr_valid;
    wire instr_ready, skip_next, watchdog_clear, prescaler_clear;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [11:0] instr_word;
    wire [7:0] accum;
    wire [4:0] status_flags;
    integer n_errors = 0, cmp_count = 0, n_skip = 0, n_wdc = 0, n_pre = 0;
    file_alu_exec i_file_alu_exec (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .instr_valid, .instr_word, .instr_ready, .skip_next,
        .watchdog_clear, .prescaler_clear, .accum, .status_flags);
    seq_model i_seq_model (.aclk, .instr_ready, .instr_valid, .instr_word);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        n_skip <= n_skip + skip_next;
        n_wdc <= n_wdc + watchdog_clear;
        n_pre <= n_pre + prescaler_clear;
    end
    task chk(input [31:0] s, input [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: %h vs %h", $time, s, e);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bs = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task rd(input [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd_v = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        rd(a);
        chk(rd_v, e);
    endtask
    task t_reset;
        rchk(8'h0C, 32'h18);
        rchk(8'h00, 32'h1);
        rchk(8'h08, 32'h0);
        rd(8'h20);
        chk(rs, 2'h2);
        wr(8'h20, 32'h0);
        chk(bs, 2'h2);
        $display("reset test done");
    endtask
    task t_lit;
        logic [11:0] w [4] = '{12'hE3C, 12'hD3C, 12'hF3C, 12'hE0F};
        logic [7:0] e [4] = '{8'h30, 8'hFC, 8'hCC, 8'h00};
        for (int i = 0; i < 4; i++) begin
            wr(8'h08, 32'hF0);
            i_seq_model.issue(w[i]);
            i_seq_model.idle();
            chk(accum, e[i]);
            chk(status_flags[2], e[i] == 0);
        end
        $display("literal test done");
    endtask
    task t_file;
        logic [6:0] op [10] = '{7'h0B, 7'h09, 7'h0D, 7'h13, 7'h15,
            7'h07, 7'h03, 7'h1D, 7'h1B, 7'h19};
        logic [7:0] ex [10] = '{8'h03, 8'hFF, 8'hFC, 8'h0C, 8'hF4,
            8'hF2, 8'h00, 8'h3F, 8'hE6, 8'hF9};
        wr(8'h10, 32'h3);
        wr(8'h08, 32'h0F);
        wr(8'h0C, 32'h0);
        for (int i = 0; i < 10; i++) begin
            wr(8'h14, 32'hF3);
            i_seq_model.issue({op[i], 5'h03});
            i_seq_model.idle();
            rchk(8'h14, ex[i]);
            if (i < 7) chk(status_flags[2], ex[i] == 0);
        end
        chk(status_flags, 5'h05);
        chk(accum, 8'h0F);
        $display("file test done");
    endtask
    task t_arith;
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h01);
        wr(8'h08, 32'h19);
        wr(8'h14, 32'h28);
        i_seq_model.issue(12'h1C3);
        i_seq_model.idle();
        chk(accum, 8'h42);
        chk(status_flags, 5'h02);
        i_seq_model.issue(12'h0A3);
        i_seq_model.idle();
        rchk(8'h14, 32'hE5);
        chk(status_flags, 5'h02);
        wr(8'h00, 32'h1);
        wr(8'h0C, 32'h01);
        i_seq_model.issue(12'h1E3);
        i_seq_model.idle();
        rchk(8'h14, 32'h27);
        chk(status_flags, 5'h01);
        i_seq_model.issue(12'h143);
        i_seq_model.idle();
        chk(accum, 8'h02);
        $display("arith test done");
    endtask
    task t_skip;
        wr(8'h0C, 32'h0);
        wr(8'h14, 32'h01);
        i_seq_model.issue(12'h2E3);
        i_seq_model.issue(12'h2A3);
        i_seq_model.issue(12'h2E3);
        i_seq_model.issue(12'h3E3);
        i_seq_model.issue(12'h263);
        i_seq_model.idle();
        rchk(8'h14, 32'h0);
        chk(status_flags, 5'h0);
        chk(n_skip, 2);
        rchk(8'h1C, 32'h2);
        $display("skip test done");
    endtask
    task t_wdog;
        wr(8'h00, 32'h2);
        i_seq_model.issue(12'h004);
        i_seq_model.issue(12'h040);
        i_seq_model.idle();
        chk(status_flags, 5'h1C);
        chk(accum, 8'h00);
        chk(n_wdc, 1);
        chk(n_pre, 1);
        wstrb <= 4'h2;
        wr(8'h04, 32'h800);
        chk(instr_ready, 1'b0);
        wstrb <= 4'h1;
        wr(8'h04, 32'h0);
        chk(instr_ready, 1'b0);
        wstrb <= 4'hF;
        wr(8'h04, 32'h0);
        chk(instr_ready, 1'b1);
        $display("watchdog test done");
    endtask
    task complete_run;
        $display("errors %0d, compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset;
        t_lit;
        t_file;
        t_arith;
        t_skip;
        t_wdog;
        complete_run;
    end
    // generous bound: all tests take a few hundred cycles
    initial begin
        #200000;
        n_errors++;
        complete_run;
    end
endmodule
